// ==== verilog/anpx_regs.sv ====
/*
  Partner ability register and expansion status register of the auto-negotiation
  sublayer, with their management read and write port.
  Assumes the negotiation engine presents each received link code word as a one-cycle
  strobe with data, and that the serial management engine issues one-cycle read and
  write strobes with a register address, all synchronous to SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module anpx_regs
  import anpx_pkg::*;
#(
  parameter bit LOCAL_NP_ABLE = 1'b1
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // management register access
  input wire logic MGMT_RD,
  input wire logic MGMT_WR,
  input wire logic [4:0] MGMT_ADDR,
  input wire logic [15:0] MGMT_WDATA,
  output logic [15:0] MGMT_RDATA,
  // command override control bit from the vendor control register
  input wire logic CMD_OVERRIDE,
  // negotiation engine status
  input wire logic LCW_VALID,
  input wire logic [15:0] LCW_DATA,
  input wire logic PD_FAULT,
  input wire logic FLP_VALID,
  // results
  output logic SELECTOR_OK,
  output logic [10:0] AUX_CTRL
);

  logic rd_exp;
  logic wr_exp;
  logic wr_partner;
  logic [2:0] partner_hdr_reg;
  logic [4:0] taf_reg;
  logic [4:0] sel_reg;
  logic [4:0] sel_next;
  logic pd_fault_reg;
  logic page_rx_reg;
  logic pnp_reg;
  logic an_able_reg;
  logic [15:0] partner_view;
  logic [15:0] exp_view;
  logic [15:0] rdata_next;

  assign rd_exp = MGMT_RD && (MGMT_ADDR == ANPX_EXPANSION_ADDR);
  assign wr_exp = MGMT_WR && (MGMT_ADDR == ANPX_EXPANSION_ADDR);
  assign wr_partner = MGMT_WR && (MGMT_ADDR == ANPX_PARTNER_ADDR);

  // partner header and ability bits come only from the received word
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      partner_hdr_reg <= ANPX_PARTNER_RESET[15:13];
      taf_reg <= ANPX_PARTNER_RESET[9:5];
    end else if (LCW_VALID) begin
      partner_hdr_reg <= LCW_DATA[ANPX_NP_BIT:ANPX_RFAULT_BIT];
      taf_reg <= LCW_DATA[ANPX_TAF_LIVE_MSB:ANPX_TAF_LSB];
    end
  end

  // selector: a received word wins over a management write in the same cycle
  always_comb begin
    sel_next = sel_reg;
    if (wr_partner && CMD_OVERRIDE) begin
      sel_next[ANPX_CW_SEL_MSB:0] = MGMT_WDATA[ANPX_CW_SEL_MSB:0];
    end
    if (LCW_VALID) begin
      sel_next = LCW_DATA[ANPX_SEL_MSB:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_reg <= ANPX_PARTNER_RESET[4:0];
    end else begin
      sel_reg <= sel_next;
    end
  end

  // flags the supported partner code; any other code, e.g. the other defined code, clears it
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SELECTOR_OK <= 1'b0;
    end else begin
      SELECTOR_OK <= (sel_next == ANPX_SEL_SUPPORTED);
    end
  end

  // reserved expansion bits drive auxiliary functions but always read back zero
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AUX_CTRL <= ANPX_AUX_RESET;
    end else if (wr_exp && CMD_OVERRIDE) begin
      AUX_CTRL <= MGMT_WDATA[15:ANPX_EXP_RSV_LSB];
    end
  end

  // latching-high fault: a present cause beats the read-clear
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pd_fault_reg <= ANPX_EXPANSION_RESET[ANPX_PD_FAULT_BIT];
    end else if (PD_FAULT) begin
      pd_fault_reg <= 1'b1;
    end else if (rd_exp) begin
      pd_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      page_rx_reg <= ANPX_EXPANSION_RESET[ANPX_PAGE_RX_BIT];
    end else if (LCW_VALID) begin
      page_rx_reg <= 1'b1;
    end else if (rd_exp) begin
      page_rx_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pnp_reg <= ANPX_EXPANSION_RESET[ANPX_PNP_BIT];
    end else if (LCW_VALID) begin
      pnp_reg <= LCW_DATA[ANPX_NP_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      an_able_reg <= ANPX_EXPANSION_RESET[ANPX_AN_ABLE_BIT];
    end else begin
      an_able_reg <= FLP_VALID;
    end
  end

  // software is expected to wait for negotiation complete before trusting these
  always_comb begin
    partner_view = '0;
    partner_view[15:13] = partner_hdr_reg;
    partner_view[12:10] = 3'h0;
    partner_view[9:5] = taf_reg;
    partner_view[4:0] = sel_reg;
    exp_view = '0;
    exp_view[ANPX_PD_FAULT_BIT] = pd_fault_reg;
    exp_view[ANPX_PNP_BIT] = pnp_reg;
    exp_view[ANPX_LNP_BIT] = LOCAL_NP_ABLE;
    exp_view[ANPX_PAGE_RX_BIT] = page_rx_reg;
    exp_view[ANPX_AN_ABLE_BIT] = an_able_reg;
    rdata_next = MGMT_RDATA;
    if (MGMT_RD) begin
      unique case (MGMT_ADDR)
        ANPX_PARTNER_ADDR: rdata_next = partner_view;
        ANPX_EXPANSION_ADDR: rdata_next = exp_view;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // read data is captured from the pre-clear value, so a flag is never lost unseen
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MGMT_RDATA <= 16'h0000;
    end else begin
      MGMT_RDATA <= rdata_next;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  a_ability_load: assert property (LCW_VALID |=> taf_reg == $past(LCW_DATA[9:5]))
    else $error("ability field not loaded from word");
  a_rsv5_zero: assert property (MGMT_RD && MGMT_ADDR == ANPX_PARTNER_ADDR
    |=> MGMT_RDATA[12:10] == 3'h0)
    else $error("reserved ability bits read nonzero");
  a_rsv6_zero: assert property (rd_exp |=> MGMT_RDATA[15:5] == 11'h000
    && MGMT_RDATA[2] == LOCAL_NP_ABLE)
    else $error("expansion read shows wrong fixed bits");
  a_cw_block: assert property (wr_exp && !CMD_OVERRIDE |=> $stable(AUX_CTRL))
    else $error("reserved bits written without override");
  a_cw_take: assert property (wr_exp && CMD_OVERRIDE |=> AUX_CTRL == $past(MGMT_WDATA[15:5]))
    else $error("override write not accepted");
  a_pd_latch: assert property (PD_FAULT ##1 (!PD_FAULT && !rd_exp)[*2] |=> pd_fault_reg)
    else $error("fault flag dropped without read");
  a_pd_clear: assert property (rd_exp && !PD_FAULT
    |=> !pd_fault_reg && MGMT_RDATA[4] == $past(pd_fault_reg))
    else $error("fault flag not cleared by read or pre-clear value lost");
  a_page_set: assert property (LCW_VALID |=> page_rx_reg && pnp_reg == $past(LCW_DATA[15]))
    else $error("page received or partner next page wrong");
  a_page_clear: assert property (rd_exp && !LCW_VALID && page_rx_reg
    |=> !page_rx_reg && MGMT_RDATA[1])
    else $error("page received not cleared after being read");
  a_an_able: assert property (FLP_VALID[*2] |=> an_able_reg)
    else $error("partner negotiation able not set");
  a_sel_ok: assert property (LCW_VALID && LCW_DATA[4:0] == ANPX_SEL_OTHER |=> !SELECTOR_OK)
    else $error("unsupported selector accepted");

endmodule : anpx_regs
`default_nettype wire

// ==== verilog/anpx_pkg.sv ====
/*
  Constants for the auto-negotiation partner ability and expansion status registers.
  Assumes a management access port that carries 5-bit register addresses and 16-bit data.
*/
`default_nettype none
package anpx_pkg;
  // register addresses on the management port
  localparam logic [4:0] ANPX_PARTNER_ADDR = 5'h05;
  localparam logic [4:0] ANPX_EXPANSION_ADDR = 5'h06;
  // field positions in the partner ability register
  localparam int ANPX_NP_BIT = 15;
  localparam int ANPX_ACK_BIT = 14;
  localparam int ANPX_RFAULT_BIT = 13;
  localparam int ANPX_TAF_LSB = 5;
  localparam int ANPX_TAF_LIVE_MSB = 9;
  localparam int ANPX_SEL_MSB = 4;
  localparam int ANPX_CW_SEL_MSB = 3;
  // field positions in the expansion status register
  localparam int ANPX_EXP_RSV_LSB = 5;
  localparam int ANPX_PD_FAULT_BIT = 4;
  localparam int ANPX_PNP_BIT = 3;
  localparam int ANPX_LNP_BIT = 2;
  localparam int ANPX_PAGE_RX_BIT = 1;
  localparam int ANPX_AN_ABLE_BIT = 0;
  // values after reset
  localparam logic [15:0] ANPX_EXPANSION_RESET = 16'h0004;
  localparam logic [15:0] ANPX_PARTNER_RESET = 16'h0000;
  localparam logic [10:0] ANPX_AUX_RESET = 11'h000;
  // the only selector code this device negotiates with; 5'h02 is the other defined code
  localparam logic [4:0] ANPX_SEL_SUPPORTED = 5'h01;
  localparam logic [4:0] ANPX_SEL_OTHER = 5'h02;
endpackage : anpx_pkg
`default_nettype wire

// ==== verif/anpx_sta.sv ====
/*
  Station management model: one-cycle read and write strobes on the management port.
  Assumes the bench calls acc and that clk is the block's SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module anpx_sta (
  // clock
  input wire logic clk,
  // management strobes
  output logic rd,
  output logic wr,
  output logic [4:0] addr,
  output logic [15:0] wdata
);
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h1f;
    wdata = 16'hffff;
  end
  // released address and data lines show the inverse so a stale value cannot pass
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    rd = ~w;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : acc
endmodule : anpx_sta
`default_nettype wire

// ==== verif/anpx_regs_test.sv ====
/*
  Self-checking bench for anpx_regs: drives the engine side, checks reads from a queue.
  Assumes anpx_sta performs every management access.
*/
`timescale 1ns/1ps
`default_nettype none
module anpx_regs_test;
  import anpx_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ovr = 1'b0;
  logic lcw_v = 1'b0;
  logic pdf = 1'b0;
  logic flp = 1'b0;
  logic rd_d = 1'b0;
  logic rd, wr, sel_ok;
  logic [4:0] addr;
  logic [15:0] wd, rdat, d, p5;
  logic [15:0] lcw = 16'h0000;
  logic [10:0] aux;
  logic [31:0] seed = 32'h0000_3ea4;
  logic [15:0] exp_q[$];
  logic [17:0] tbl[5] = '{18'h1_0014, 18'h0_0014, 18'h0_0004, 18'h2_0005, 18'h0_0004};
  int n_errors = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  anpx_regs i_dut (.SYS_CLK(clk), .ARST_N(arst_n), .MGMT_RD(rd), .MGMT_WR(wr),
    .MGMT_ADDR(addr), .MGMT_WDATA(wd), .MGMT_RDATA(rdat), .CMD_OVERRIDE(ovr),
    .LCW_VALID(lcw_v), .LCW_DATA(lcw), .PD_FAULT(pdf), .FLP_VALID(flp),
    .SELECTOR_OK(sel_ok), .AUX_CTRL(aux));
  anpx_sta i_sta (.clk(clk), .rd(rd), .wr(wr), .addr(addr), .wdata(wd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_sta.acc(1'b0, a, 16'h0000);
  endtask : rd_exp
  task automatic pulse(input logic [15:0] w);
    @(negedge clk);
    lcw_v = 1'b1;
    lcw = w;
    @(negedge clk);
    lcw_v = 1'b0;
    lcw = ~w;
  endtask : pulse
  task automatic final_report;
    $display("counts: compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // read data is valid in the cycle after the strobe edge
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      chk(rdat, exp_q.pop_front(), "read");
    end
  end
  initial begin
    #(25 * 2000);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    rd_exp(ANPX_EXPANSION_ADDR, ANPX_EXPANSION_RESET);
    rd_exp(ANPX_PARTNER_ADDR, ANPX_PARTNER_RESET);
    rd_exp(5'h1d, 16'h0000);
    $display("test reset done");
    foreach (tbl[i]) begin
      flp = tbl[i][17];
      pdf = tbl[i][16];
      // idle cycles before the read; pdf and flp stay applied through it, so the latch holds on its own only once pdf drops
      repeat (3) @(negedge clk);
      rd_exp(ANPX_EXPANSION_ADDR, tbl[i][15:0]);
    end
    $display("test flags done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = seed[15:0];
      if (i < 2) begin
        d[4:0] = (i == 0) ? ANPX_SEL_SUPPORTED : ANPX_SEL_OTHER;
      end
      pulse(d);
      p5 = {d[15:13], 3'b000, d[9:0]};
      chk({15'h0000, sel_ok}, {15'h0000, d[4:0] == ANPX_SEL_SUPPORTED}, "sel");
      rd_exp(ANPX_PARTNER_ADDR, p5);
      rd_exp(ANPX_EXPANSION_ADDR, {12'h000, d[15], 3'b110});
      rd_exp(ANPX_EXPANSION_ADDR, {12'h000, d[15], 3'b100});
    end
    $display("test words done");
    for (int ov = 0; ov < 2; ov++) begin
      ovr = ov[0];
      seed = xs(seed);
      i_sta.acc(1'b1, ANPX_EXPANSION_ADDR, seed[15:0]);
      i_sta.acc(1'b1, ANPX_PARTNER_ADDR, 16'h000a);
      p5 = (ov == 1) ? {p5[15:4], 4'ha} : p5;
      rd_exp(ANPX_PARTNER_ADDR, p5);
      rd_exp(ANPX_EXPANSION_ADDR, {12'h000, d[15], 3'b100});
      chk({5'h00, aux}, (ov == 1) ? {5'h00, seed[15:5]} : 16'h0000, "aux");
    end
    $display("test writes done");
    repeat (3) @(negedge clk);
    final_report();
  end
endmodule : anpx_regs_test
`default_nettype wire
